// [shared/flash_defs.svh]
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// Device command codes
`define FL_CMD_EXT_STATUS 8'h71
`define FL_CMD_SWAP       8'h72
`define FL_CMD_LOAD_BUF   8'h74
`define FL_CMD_READ_BUF   8'h75
`define FL_CMD_SEQ_LOAD   8'hE0
`define FL_CMD_BUF_PROG   8'h0C
`define FL_CMD_TWO_BYTE   8'hFB
`define FL_CMD_BLK_ERASE  8'h20
`define FL_CMD_ERASE_ALL  8'hA7
`define FL_CMD_CONFIRM    8'hD0
`define FL_CMD_LOCK       8'h77
`define FL_CMD_UPLOAD     8'h97
`define FL_CMD_RYBY       8'h96
`define FL_CMD_SLEEP      8'hF0
`define FL_CMD_ABORT      8'h80
`define FL_CMD_CLEAR      8'h50
`define FL_CMD_READ_CSR   8'h70
`define FL_COUNT_HIGH     8'h00

// Register byte offsets
`define REG_CMD    5'h00
`define REG_ADDR   5'h04
`define REG_DATA   5'h08
`define REG_DATA2  5'h0C
`define REG_RESULT 5'h10
`define REG_STATUS 5'h14
`define REG_CONFIG 5'h18

// Field positions
`define CMD_RESUME_BIT  8
`define ST_BUSY_BIT     0
`define ST_READY_BIT    1
`define ST_REFUSED_BIT  2
`define ST_LEFT_LSB     8
`define CFG_WORD_BIT    0

// Bus cycle timing
`define FL_CLK_NS     25
`define FL_SETUP_NS   25
`define FL_STROBE_NS  100
`define FL_HOLD_NS    25
`define FL_SETUP_CYC  ((`FL_SETUP_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_STROBE_CYC ((`FL_STROBE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_HOLD_CYC   ((`FL_HOLD_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

`endif

// [shared/flash_pkg.sv]
package flash_pkg;

  // Operations that software may order
  typedef enum logic [4:0] {
    OP_EXT_STATUS, OP_SWAP, OP_READ_BUF, OP_LOAD_BUF, OP_SEQ_LOAD, OP_PAIR,
    OP_BUF_PROG, OP_TWO_BYTE, OP_BLK_ERASE, OP_ERASE_ALL, OP_LOCK, OP_UPLOAD,
    OP_RYBY, OP_SLEEP, OP_ABORT, OP_CLEAR, OP_READ_CSR, OP_READ
  } op_t;

  // Phases of one device bus cycle
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} bus_state_t;

endpackage

// [rtl/flash_cmd_host.sv]
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "flash_defs.svh"

// What this block does
// - 71H then read at status address
// - 75H read or 74H write buffer datum
// - E0H, count low, count high, then pairs
// - Host always writes zero high count
// - Program destination equals buffer source address
// - FBH byte mode only, A0 order
// - 20H/A7H then D0H, optional third D0H
// - 97H D0H uploads locks; 77H D0H locks
module flash_cmd_host
  import flash_pkg::*;
(
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        nrst,
  // Avalon-MM slave
  input  wire  logic [4:0]  address,
  input  wire  logic        read,
  input  wire  logic        write,
  input  wire  logic [31:0] writedata,
  output logic       [31:0] readdata,
  output logic              waitrequest,
  // Flash device pins
  output logic       [20:0] fl_addr,
  input  wire  logic [15:0] fl_dq_in,
  output logic       [15:0] fl_dq_out,
  output logic              fl_dq_oe,
  output logic              fl_ce_n,
  output logic              fl_oe_n,
  output logic              fl_we_n,
  output logic              fl_byte_n,
  input  wire  logic        ready_busy_out
);

  bus_state_t  st;
  op_t         op;
  logic        resume, word_mode, refused;
  logic [1:0]  step;
  logic [2:0]  cnt, phase_len;
  logic [20:0] addr_r, cyc_addr;
  logic [15:0] data_r, data2_r, result, cyc_data;
  logic [8:0]  seq_left;
  logic [15:0] dq_meta, dq_sync;
  logic        rb_meta, rb_sync;
  logic        cyc_read, cyc_last;
  logic        bus_take, cmd_write, op_legal, start, phase_end;
  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake
  // Answer one cycle after a request, then drop for one cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end
  assign bus_take  = write && !waitrequest;
  assign cmd_write = bus_take && (address == `REG_CMD);
  assign op_legal  = (writedata[4:0] <= OP_READ) &&
                     !(writedata[4:0] == OP_TWO_BYTE && word_mode);
  assign start     = cmd_write && (st == ST_IDLE) && op_legal;
  // Read data mux, registered while waitrequest is high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      unique case (address)
        `REG_CMD:    readdata <= {23'h000000, resume, 3'h0, op};
        `REG_ADDR:   readdata <= {11'h000, addr_r};
        `REG_DATA:   readdata <= {16'h0000, data_r};
        `REG_DATA2:  readdata <= {16'h0000, data2_r};
        `REG_RESULT: readdata <= {16'h0000, result};
        `REG_STATUS: readdata <= {15'h0000, seq_left, 5'h00, refused,
                                  rb_sync, (st != ST_IDLE)};
        `REG_CONFIG: readdata <= {31'h00000000, word_mode};
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  // Operand and configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_r    <= 21'h000000;
      data_r    <= 16'h0000;
      data2_r   <= 16'h0000;
      word_mode <= 1'b0;
    end else if (bus_take) begin
      if (address == `REG_ADDR) addr_r <= writedata[20:0];
      if (address == `REG_DATA) data_r <= writedata[15:0];
      if (address == `REG_DATA2) data2_r <= writedata[15:0];
      if (address == `REG_CONFIG && st == ST_IDLE) word_mode <= writedata[`CFG_WORD_BIT];
    end
  end
  // Latched operation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      op     <= OP_READ;
      resume <= 1'b0;
    end else if (start) begin
      op     <= op_t'(writedata[4:0]);
      resume <= writedata[`CMD_RESUME_BIT];
    end
  end
  // Orders refused while busy or illegal
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refused <= 1'b0;
    end else if (cmd_write) begin
      refused <= !start;
    end
  end
  // Pairs still owed after a sequential load
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seq_left <= 9'h000;
    end else if (start && writedata[4:0] == OP_SEQ_LOAD) begin
      seq_left <= {1'b0, data_r[7:0]} + 9'h001;
    end else if (start && writedata[4:0] == OP_PAIR && seq_left != 9'h000) begin
      seq_left <= seq_left - 9'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Two flops before any use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      dq_meta <= fl_dq_in;
      dq_sync <= dq_meta;
      rb_meta <= ready_busy_out;
      rb_sync <= rb_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequence decode
  // Bus cycle for the current step; step 0 opens with a command code except for OP_PAIR and OP_READ
  always_comb begin
    cyc_read = 1'b0;
    cyc_last = 1'b0;
    cyc_addr = addr_r;
    cyc_data = 16'h0000;
    unique case (op)
      OP_EXT_STATUS: begin
        cyc_data = {8'h00, `FL_CMD_EXT_STATUS};
        cyc_read = (step != 2'd0);
        cyc_last = (step != 2'd0);
      end
      OP_SWAP: begin
        cyc_data = {8'h00, `FL_CMD_SWAP};
        cyc_last = 1'b1;
      end
      OP_READ_BUF: begin
        cyc_data = {8'h00, `FL_CMD_READ_BUF};
        cyc_read = (step != 2'd0);
        cyc_last = (step != 2'd0);
      end
      OP_LOAD_BUF: begin
        cyc_data = (step == 2'd0) ? {8'h00, `FL_CMD_LOAD_BUF} : data_r;
        cyc_last = (step != 2'd0);
      end
      OP_SEQ_LOAD: begin
        unique case (step)
          2'd0:    cyc_data = {8'h00, `FL_CMD_SEQ_LOAD};
          2'd1:    cyc_data = {8'h00, data_r[7:0]};
          default: cyc_data = {8'h00, `FL_COUNT_HIGH};
        endcase
        cyc_last = (step == 2'd2);
      end
      OP_PAIR: begin
        cyc_data = data_r;
        cyc_last = 1'b1;
      end
      OP_BUF_PROG: begin
        unique case (step)
          2'd0:    cyc_data = {8'h00, `FL_CMD_BUF_PROG};
          2'd1: begin
            cyc_addr = {addr_r[20:1], 1'b0};
            cyc_data = {8'h00, data_r[7:0]};
          end
          default: cyc_data = {8'h00, `FL_COUNT_HIGH};
        endcase
        cyc_last = (step == 2'd2);
      end
      OP_TWO_BYTE: begin
        unique case (step)
          2'd0:    cyc_data = {8'h00, `FL_CMD_TWO_BYTE};
          2'd1:    cyc_data = {8'h00, data_r[7:0]};
          default: cyc_data = {8'h00, data2_r[7:0]};
        endcase
        cyc_last = (step == 2'd2);
      end
      OP_BLK_ERASE, OP_ERASE_ALL: begin
        cyc_data = (step != 2'd0)       ? {8'h00, `FL_CMD_CONFIRM}
                 : (op == OP_BLK_ERASE) ? {8'h00, `FL_CMD_BLK_ERASE}
                 :                        {8'h00, `FL_CMD_ERASE_ALL};
        cyc_last = (step == 2'd2) || (step == 2'd1 && !resume);
      end
      OP_LOCK, OP_UPLOAD: begin
        cyc_data = (step != 2'd0)  ? {8'h00, `FL_CMD_CONFIRM}
                 : (op == OP_LOCK) ? {8'h00, `FL_CMD_LOCK}
                 :                   {8'h00, `FL_CMD_UPLOAD};
        cyc_last = (step != 2'd0);
      end
      OP_RYBY: begin
        cyc_data = (step == 2'd0) ? {8'h00, `FL_CMD_RYBY} : {8'h00, data_r[7:0]};
        cyc_last = (step != 2'd0);
      end
      OP_SLEEP: begin
        cyc_data = {8'h00, `FL_CMD_SLEEP};
        cyc_last = 1'b1;
      end
      OP_ABORT: begin
        cyc_data = {8'h00, `FL_CMD_ABORT};
        cyc_last = 1'b1;
      end
      OP_CLEAR: begin
        cyc_data = {8'h00, `FL_CMD_CLEAR};
        cyc_last = 1'b1;
      end
      OP_READ_CSR: begin
        cyc_data = {8'h00, `FL_CMD_READ_CSR};
        cyc_read = (step != 2'd0);
        cyc_last = (step != 2'd0);
      end
      OP_READ: begin
        cyc_read = 1'b1;
        cyc_last = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine
  // Length of the current phase
  always_comb begin
    unique case (st)
      ST_SETUP:  phase_len = 3'(`FL_SETUP_CYC);
      ST_STROBE: phase_len = 3'(`FL_STROBE_CYC);
      ST_HOLD:   phase_len = 3'(`FL_HOLD_CYC);
      ST_IDLE:   phase_len = 3'h1;
    endcase
  end
  assign phase_end = (cnt == phase_len - 3'h1);
  // Phase sequencer; after the last step it waits for a new first cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st   <= ST_IDLE;
      step <= 2'd0;
      cnt  <= 3'h0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          cnt <= 3'h0;
          if (start) begin
            st   <= ST_SETUP;
            step <= 2'd0;
          end
        end
        ST_SETUP, ST_STROBE: begin
          cnt <= phase_end ? 3'h0 : cnt + 3'h1;
          if (phase_end) st <= (st == ST_SETUP) ? ST_STROBE : ST_HOLD;
        end
        ST_HOLD: begin
          cnt <= phase_end ? 3'h0 : cnt + 3'h1;
          if (phase_end) begin
            if (cyc_last) begin
              st   <= ST_IDLE;
              step <= 2'd0;
            end else begin
              st   <= ST_SETUP;
              step <= step + 2'd1;
            end
          end
        end
      endcase
    end
  end
  // Read data captured at the close of a read cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      result <= 16'h0000;
    end else if (st == ST_HOLD && phase_end && cyc_read) begin
      result <= word_mode ? dq_sync : {8'h00, dq_sync[7:0]};
    end
  end
  // Pins follow the phase one cycle later, keeping phase lengths intact
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fl_addr   <= 21'h000000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe  <= 1'b0;
      fl_ce_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_byte_n <= 1'b0;
    end else begin
      fl_addr   <= cyc_addr;
      fl_dq_out <= cyc_data;
      fl_dq_oe  <= (st != ST_IDLE) && !cyc_read;
      fl_ce_n   <= (st == ST_IDLE);
      fl_oe_n   <= !(st == ST_STROBE && cyc_read);
      fl_we_n   <= !(st == ST_STROBE && !cyc_read);
      fl_byte_n <= word_mode;
    end
  end

endmodule

// [test/flash_cmd_host_asserts.sv]
`timescale 1ns/1ps
module flash_cmd_host_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Bus side
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Device pins
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic        fl_dq_oe,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_req_answered: assert property ((read || write) && waitrequest |-> ##[1:3] !waitrequest)
    else $error("request not answered");
  ////////////////////////////////////////////////////////////////////////////////
  // Device strobes
  chk_strobe_excl: assert property (!(!fl_we_n && !fl_oe_n))
    else $error("write and read strobes together");
  chk_we_in_ce: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe outside chip enable");
  chk_oe_in_ce: assert property (!fl_oe_n |-> !fl_ce_n)
    else $error("read strobe outside chip enable");
  chk_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
    else $error("write strobe width wrong");
  chk_we_setup: assert property ($fell(fl_we_n) |-> $past(!fl_ce_n))
    else $error("no setup before write strobe");
  chk_dq_driven: assert property (!fl_we_n |-> fl_dq_oe)
    else $error("data not driven in write");
  chk_dq_released: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("data driven during read");
  chk_data_stable: assert property (!fl_we_n && $past(!fl_we_n)
    |-> $stable(fl_dq_out) && $stable(fl_addr))
    else $error("data moved in write strobe");
  // Main scenarios
  cov_write_cycle: cover property ($rose(fl_we_n));
  cov_read_cycle: cover property ($rose(fl_oe_n));
  cov_bus_write: cover property (write && !waitrequest);
endmodule
bind flash_cmd_host flash_cmd_host_asserts chk (.clk(clk), .nrst(nrst), .read(read),
  .write(write), .waitrequest(waitrequest), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// [test/flash_dev_model.sv]
`timescale 1ns/1ps
module flash_dev_model (
  // Host pins
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  // Device outputs
  output logic     [15:0] fl_dq_in,
  output logic            ready_busy_out
);
  logic [7:0] log_d [0:63];
  logic [20:0] log_a [0:63];
  logic [7:0] pb;
  logic [7:0] last;
  logic [7:0] global_status;
  logic [7:0] compatible_status;
  logic [15:0] val;
  int         nw;
  // Idle device, buffer free and ready
  initial begin
    nw = 0;
    last = 8'hFF;
    pb = 8'h00;
    global_status = 8'h86;
    compatible_status = 8'h80;
  end
  // Write cycle logging and command effects
  always @(posedge fl_we_n) if (!fl_ce_n) begin
    log_d[nw[5:0]] = fl_dq_out[7:0];
    log_a[nw[5:0]] = fl_addr;
    nw++;
    // Datum after a single-load command goes to the buffer
    if (last == 8'h74) pb = fl_dq_out[7:0];
    // Anything but a confirm after an erase code is a bad sequence
    if ((last == 8'h20 || last == 8'hA7) && fl_dq_out[7:0] != 8'hD0)
      compatible_status[5:4] = 2'b11;
    last = fl_dq_out[7:0];
    case (fl_dq_out[7:0])
      8'h72: global_status[0] = ~global_status[0];
      8'hD0: compatible_status[3] = 1'b0; // supply sampled only on confirm
      8'hF0: global_status[5:4] = 2'b01;
      8'h80: global_status[5:4] = 2'b11;
      8'h50: begin
        global_status[5] = 1'b0;
        compatible_status[5:3] = 3'h0;
      end
      default: ;
    endcase
  end
  // Status by address after extended read, buffer byte after 75H, else compatible status
  always @* begin
    if (last == 8'h71)
      val = {8'h00, (fl_addr[2:0] == 3'h4) ? global_status : 8'h80};
    else if (last == 8'h75)
      val = {8'h00, pb};
    else
      val = {8'h00, compatible_status};
  end
  // Released bus shows the inverse
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? val : ~val;
  assign ready_busy_out = 1'b1;
endmodule

// [test/test_flash_cmd_host.sv]
`timescale 1ns/1ps
`include "flash_defs.svh"
module test_flash_cmd_host;
  import flash_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic        waitrequest;
  logic [20:0] fl_addr;
  logic [15:0] fl_dq_in;
  logic [15:0] fl_dq_out;
  logic        fl_dq_oe;
  logic        fl_ce_n;
  logic        fl_oe_n;
  logic        fl_we_n;
  logic        fl_byte_n;
  logic        ready_busy_out;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n0;
  always #12.5 clk = ~clk;
  flash_cmd_host uut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n), .ready_busy_out(ready_busy_out));
  flash_dev_model m (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in), .ready_busy_out(ready_busy_out));
  ////////////////////////////////////////////////////////////////////////////////
  // Closing report
  task finish_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One bus access, held until waitrequest low
  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // Order an operation and poll until idle
  task run(input op_t op, input logic [20:0] a, input logic [7:0] d, input logic r);
    n0 = m.nw;
    av(1'b1, `REG_ADDR, {11'h0, a});
    av(1'b1, `REG_DATA, {24'h0, d});
    av(1'b1, `REG_CMD, {23'h0, r, 3'h0, op});
    repeat (40) begin
      av(1'b0, `REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 1'b0);
  endtask
  task seq(input op_t op, input logic [20:0] a, input logic [7:0] d, input logic r,
           input int n, input logic [23:0] b);
    run(op, a, d, r);
    chk(m.nw - n0, n);
    for (int i = 0; i < n; i++) chk(m.log_d[6'(n0 + i)], b[23 - 8 * i -: 8]);
  endtask
  task gsr_rd;
    run(OP_EXT_STATUS, 21'h4, 8'h00, 1'b0);
    av(1'b0, `REG_RESULT, 32'h0);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    seq(OP_SWAP, 21'h0, 8'h00, 1'b0, 1, 24'h720000);
    gsr_rd;
    chk(rd[7:0], 8'h87);
    seq(OP_SEQ_LOAD, 21'h0, 8'h00, 1'b0, 3, 24'hE00000);
    av(1'b0, `REG_STATUS, 32'h0);
    chk(rd[16:8], 9'h001);
    seq(OP_PAIR, 21'h7, 8'hA5, 1'b0, 1, 24'hA50000);
    av(1'b0, `REG_STATUS, 32'h0);
    chk(rd[16:8], 9'h000);
    seq(OP_BLK_ERASE, 21'h10000, 8'h00, 1'b0, 2, 24'h20D000);
    seq(OP_ERASE_ALL, 21'h0, 8'h00, 1'b1, 3, 24'hA7D0D0);
    gsr_rd;
    chk(rd[7], 1'b1);
    seq(OP_LOCK, 21'h10000, 8'h00, 1'b0, 2, 24'h77D000);
    seq(OP_UPLOAD, 21'h0, 8'h00, 1'b0, 2, 24'h97D000);
    for (int k = 1; k < 5; k++) seq(OP_RYBY, 21'h0, k[7:0], 1'b0, 2, {8'h96, k[7:0], 8'h00});
    seq(OP_SLEEP, 21'h0, 8'h00, 1'b0, 1, 24'hF00000);
    gsr_rd;
    chk(rd[5:4], 2'b01);
    seq(OP_ABORT, 21'h0, 8'h00, 1'b0, 1, 24'h800000);
    gsr_rd;
    chk(rd[5:4], 2'b11);
    seq(OP_CLEAR, 21'h0, 8'h00, 1'b0, 1, 24'h500000);
    gsr_rd;
    chk(rd[5], 1'b0);
    run(OP_READ_CSR, 21'h0, 8'h00, 1'b0);
    av(1'b0, `REG_RESULT, 32'h0);
    chk(rd[7:0], 8'h80);
    // Buffer load and read back, buffer program, plain read
    seq(OP_LOAD_BUF, 21'h3, 8'h5A, 1'b0, 2, 24'h745A00);
    run(OP_READ_BUF, 21'h3, 8'h00, 1'b0);
    av(1'b0, `REG_RESULT, 32'h0);
    chk(rd[7:0], 8'h5A);
    seq(OP_BUF_PROG, 21'h101, 8'h00, 1'b0, 3, 24'h0C0000);
    chk(m.log_a[6'(n0 + 1)], 21'h100);
    chk(m.log_a[6'(n0 + 2)], 21'h101);
    run(OP_READ, 21'h0, 8'h00, 1'b0);
    av(1'b0, `REG_RESULT, 32'h0);
    chk(rd[7:0], 8'h80);
    // Two-byte write refused in word mode, then done in byte mode
    av(1'b1, `REG_CONFIG, 32'h1);
    run(OP_TWO_BYTE, 21'h21, 8'h11, 1'b0);
    chk(fl_byte_n, 1'b1);
    chk(m.nw - n0, 0);
    av(1'b0, `REG_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    av(1'b1, `REG_CONFIG, 32'h0);
    seq(OP_TWO_BYTE, 21'h21, 8'h11, 1'b0, 3, 24'hFB1100);
    av(1'b0, 5'h1C, 32'h0);
    chk(rd, 32'h0);
    finish_test;
  end
endmodule
